// ---- inc/ffrr_pkg.sv ----
package ffrr_pkg;

	// ***********************************************************
	// Register map at the printed byte addresses.
	// ***********************************************************
	localparam logic [9:0] ADDR_DATA_PORT = 10'h3f5; // Data port.
	localparam logic [9:0] ADDR_DIR_RATE = 10'h3f7; // Input status on read, rate on write.

	// ***********************************************************
	// Compatibility layouts of the input and rate registers.
	// ***********************************************************
	localparam logic [1:0] MODE_LAYOUT1 = 2'h0; // Only bit 7 driven.
	localparam logic [1:0] MODE_LAYOUT2 = 2'h1; // Rate code and density shown.
	localparam logic [1:0] MODE_LAYOUT3 = 2'h2; // Gate and precomp shown.

	// ***********************************************************
	// Field positions and reset values.
	// ***********************************************************
	localparam int RATE_LSB = 0; // Rate code field base.
	localparam int PRECOMP_BIT = 2; // Precomp disable bit.
	localparam logic [1:0] RATE_RST = 2'h2; // 250 Kbps code.
	localparam logic DENS_RST = 1'b1; // Density select after reset.
	localparam logic [3:0] THR_RST = 4'h0; // Threshold after reset.

	// ***********************************************************
	// Storage sizes.
	// ***********************************************************
	localparam int FIFO_DEPTH = 16; // Bytes of buffering.
	localparam logic [4:0] FIFO_DEPTH_C = 5'h10; // Depth at count width.

	// Command phase, one-hot.
	typedef enum logic [2:0] {
		PH_CMD = 3'b001,
		PH_EXEC = 3'b010,
		PH_HALT = 3'b100
	} ffrr_phase_t;

	// Density select level for a rate code: high for 500 Kbps and 1 Mbps.
	function automatic logic dens_of(input logic [1:0] code);
		dens_of = (code == 2'h0) || (code == 2'h3);
	endfunction

endpackage

// ---- hdl/ffrr_byte_fifo.sv ----
`timescale 1ns/1ps
// Byte FIFO held in flip-flops; in single mode it holds one byte only.
module ffrr_byte_fifo (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_single,
	input wire logic i_flush,
	input wire logic i_push,
	input wire logic [7:0] i_data,
	input wire logic i_pop,
	output logic [7:0] o_head,
	output logic [4:0] o_count,
	output logic o_full,
	output logic o_empty
);
	logic [7:0] mem_r [ffrr_pkg::FIFO_DEPTH]; // Storage.
	logic [3:0] wptr_r; // Write index.
	logic [3:0] rptr_r; // Read index.
	logic [4:0] cnt_r; // Bytes held.
	wire do_push = i_push && !o_full; // Pushes into a full FIFO are dropped.
	wire do_pop = i_pop && !o_empty; // Pops from an empty FIFO are dropped.

	assign o_head = mem_r[rptr_r];
	assign o_count = cnt_r;
	assign o_empty = (cnt_r == 5'h00);
	// Single mode keeps the old one-byte register behaviour.
	assign o_full = i_single ? !o_empty : (cnt_r == ffrr_pkg::FIFO_DEPTH_C);

	// Pointers and count; a flush wins over any transfer in that cycle.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wptr_r <= 4'h0;
			rptr_r <= 4'h0;
			cnt_r <= 5'h00;
		end else if (i_flush) begin
			wptr_r <= 4'h0;
			rptr_r <= 4'h0;
			cnt_r <= 5'h00;
		end else begin
			wptr_r <= wptr_r + 4'(do_push);
			rptr_r <= rptr_r + 4'(do_pop);
			cnt_r <= cnt_r + 5'(do_push) - 5'(do_pop);
		end
	end

	// Data storage needs no reset; a byte is only read after it is written.
	always_ff @(posedge i_clk) begin
		if (do_push) begin
			mem_r[wptr_r] <= i_data;
		end
	end
endmodule

// ---- hdl/ffrr_dir_mux.sv ----
`timescale 1ns/1ps
// Builds the digital input status byte and its per-bit drive enables.
module ffrr_dir_mux (
	input wire logic [1:0] i_mode,
	input wire logic i_media_changed_n,
	input wire logic i_force_chg_en,
	input wire logic i_force_chg_val,
	input wire logic [1:0] i_rate_select_code,
	input wire logic i_precomp_disable,
	input wire logic i_transfer_gate_enable,
	output logic [7:0] o_data,
	output logic [7:0] o_oe
);
	// The forced value overrides the inverted cable level.
	wire media_changed = i_force_chg_en ? i_force_chg_val : !i_media_changed_n;
	wire low_rate_indicator = !ffrr_pkg::dens_of(i_rate_select_code);
	wire is_l1 = (i_mode == ffrr_pkg::MODE_LAYOUT1);
	wire is_l2 = (i_mode == ffrr_pkg::MODE_LAYOUT2);
	wire [7:0] l2_byte = {media_changed, 4'hf, i_rate_select_code, low_rate_indicator};
	wire [7:0] l3_byte = {media_changed, 3'h0, i_transfer_gate_enable,
		i_precomp_disable, i_rate_select_code};

	// Layout 1 drives only bit 7; the low bits float on the bus.
	assign o_oe = is_l1 ? 8'h80 : 8'hff;
	assign o_data = is_l1 ? {media_changed, 7'h00} : (is_l2 ? l2_byte : l3_byte);
endmodule

// ---- hdl/ffrr_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - All bytes pass the one data port.
// - Host transfers only when flags allow.
// - Any reset leaves FIFO disabled.
// - Configure enables FIFO and sets threshold.
// - Each command starts with buffering off.
// - Execution start flushes the FIFO.
// - Overrun or underrun terminates the command.
// - Write underrun still finishes current sector.
// - Layout one drives only bit seven.
// - Bit seven shows media change state.
// - Layout two bit zero low at high rates.
// - Layout two shows rate code, bits three-six one.
// - Rate survives soft reset, hard gives 250.
// - Layout three bit three mirrors gate.
// - Layout three bit two is precomp.
// - Rate register write loads rate code.
// - Precomp flag stored, inert, soft-reset safe.
// - Density select high after hard reset.
// - Latest rate write of either wins.
// - Ready flag high only when allowed.
// - Direction flag high means host reads.
module ffrr_top (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [9:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic [7:0] o_rdata_oe,
	input wire logic i_soft_reset,
	input wire logic [1:0] i_compat_mode,
	input wire logic i_cfg_load,
	input wire logic i_cfg_fifo_en,
	input wire logic [3:0] i_cfg_threshold,
	input wire logic i_cmd_start,
	input wire logic i_exec_start,
	input wire logic i_core_dir,
	input wire logic i_disk_write,
	input wire logic i_core_tx_valid,
	input wire logic [7:0] i_core_tx_data,
	output logic o_core_tx_ready,
	output logic o_core_rx_valid,
	output logic [7:0] o_core_rx_data,
	input wire logic i_core_rx_ready,
	input wire logic i_dsr_rate_wr,
	input wire logic [1:0] i_dsr_rate,
	input wire logic i_media_changed_n,
	input wire logic i_force_chg_en,
	input wire logic i_force_chg_val,
	input wire logic i_transfer_gate_enable,
	output logic o_host_transfer_ready,
	output logic o_transfer_direction,
	output logic o_service_req,
	output logic o_xfer_abort,
	output logic o_finish_sector,
	output logic [1:0] o_rate_select_code,
	output logic o_precomp_disable,
	output logic o_density_select_out
);

	// ***********************************************************
	// Address decode.
	// ***********************************************************

	// Data port strobes.
	wire dp_wr = i_wr && (i_addr == ffrr_pkg::ADDR_DATA_PORT);
	wire dp_rd = i_rd && (i_addr == ffrr_pkg::ADDR_DATA_PORT);
	// Rate register write and status register read share one address.
	wire rate_wr = i_wr && (i_addr == ffrr_pkg::ADDR_DIR_RATE);
	wire dir_rd = i_rd && (i_addr == ffrr_pkg::ADDR_DIR_RATE);
	wire is_l3 = (i_compat_mode == ffrr_pkg::MODE_LAYOUT3);

	// ***********************************************************
	// Configuration and command phase.
	// ***********************************************************

	logic fifo_en_r; // FIFO enabled by configure.
	logic fifo_en_nxt;
	logic [3:0] thr_r; // Service threshold in bytes.
	logic [3:0] thr_nxt;
	ffrr_pkg::ffrr_phase_t phase_r; // Where the command stands.
	ffrr_pkg::ffrr_phase_t phase_nxt;

	// Soft reset also counts as a reset and forces the compatible mode.
	assign fifo_en_nxt = i_soft_reset ? 1'b0 :
		(i_cfg_load ? i_cfg_fifo_en : fifo_en_r);
	assign thr_nxt = i_soft_reset ? ffrr_pkg::THR_RST :
		(i_cfg_load ? i_cfg_threshold : thr_r);

	// Buffering is live only in the execution phase of a command.
	wire in_exec = (phase_r == ffrr_pkg::PH_EXEC);
	wire halted = (phase_r == ffrr_pkg::PH_HALT);
	wire fifo_active = fifo_en_r && in_exec;

	// ***********************************************************
	// Data port FIFO and its handshakes.
	// ***********************************************************

	wire [7:0] head; // Oldest byte.
	wire [4:0] count; // Bytes held.
	wire full; // No room for another byte.
	wire empty; // Nothing held.
	wire xfer_err; // Overrun or underrun this cycle.
	wire flush; // Drop everything held.

	// The ready flag follows fill level in the indicated direction.
	assign o_host_transfer_ready = !halted && (i_core_dir ? !empty : !full);
	assign o_transfer_direction = i_core_dir;

	// Host accesses that the flags do not allow are ignored.
	wire host_push = dp_wr && o_host_transfer_ready && !i_core_dir;
	wire host_pop = dp_rd && o_host_transfer_ready && i_core_dir;

	// Core side: it fills toward the host when the direction is read.
	assign o_core_tx_ready = i_core_dir && !full && !halted;
	assign o_core_rx_valid = !i_core_dir && !empty && !halted;
	assign o_core_rx_data = head;
	wire core_push = i_core_tx_valid && o_core_tx_ready;
	wire core_pop = i_core_rx_ready && o_core_rx_valid;

	// Only one side pushes for a given direction, so a plain mux is safe.
	wire fifo_push = host_push || core_push;
	wire fifo_pop = host_pop || core_pop;
	wire [7:0] fifo_din = i_core_dir ? i_core_tx_data : i_wdata;

	// Overrun: disk byte arrives with no room. Underrun: disk needs a byte.
	wire overrun = in_exec && i_core_dir && i_core_tx_valid && full;
	wire underrun = in_exec && !i_core_dir && i_core_rx_ready && empty;
	assign xfer_err = overrun || underrun;

	// Stale bytes must never cross into a new execution phase.
	assign flush = i_exec_start || xfer_err || i_soft_reset;

	ffrr_byte_fifo u_fifo (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_single(!fifo_active),
		.i_flush(flush),
		.i_push(fifo_push),
		.i_data(fifo_din),
		.i_pop(fifo_pop),
		.o_head(head),
		.o_count(count),
		.o_full(full),
		.o_empty(empty)
	);

	// Threshold request gives the host the margin it must meet.
	wire [4:0] room = ffrr_pkg::FIFO_DEPTH_C - count;
	wire [4:0] thr_w = {1'b0, thr_r};
	assign o_service_req = fifo_active && (i_core_dir ? (count > thr_w) : (room > thr_w));

	// Phase changes: soft reset or command start first, then error, then execution start.
	always_comb begin
		phase_nxt = phase_r;
		if (i_soft_reset || i_cmd_start) begin
			phase_nxt = ffrr_pkg::PH_CMD;
		end else if (xfer_err) begin
			phase_nxt = ffrr_pkg::PH_HALT;
		end else if (i_exec_start) begin
			phase_nxt = ffrr_pkg::PH_EXEC;
		end else begin
			case (phase_r)
				ffrr_pkg::PH_CMD,
				ffrr_pkg::PH_EXEC,
				ffrr_pkg::PH_HALT: phase_nxt = phase_r;
				default: phase_nxt = ffrr_pkg::PH_CMD;
			endcase
		end
	end

	// Command state registers.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fifo_en_r <= 1'b0;
			thr_r <= ffrr_pkg::THR_RST;
			phase_r <= ffrr_pkg::PH_CMD;
		end else begin
			fifo_en_r <= fifo_en_nxt;
			thr_r <= thr_nxt;
			phase_r <= phase_nxt;
		end
	end

	// ***********************************************************
	// Termination reporting.
	// ***********************************************************

	logic abort_r; // One-cycle terminate pulse to the core.
	logic fin_r; // Core must finish the sector before ending.
	logic fin_nxt;

	// The sector-finish demand lasts until the next command or reset.
	assign fin_nxt = (underrun && i_disk_write) ? 1'b1 :
		((i_cmd_start || i_soft_reset) ? 1'b0 : fin_r);

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			abort_r <= 1'b0;
			fin_r <= 1'b0;
		end else begin
			abort_r <= xfer_err;
			fin_r <= fin_nxt;
		end
	end
	assign o_xfer_abort = abort_r;
	assign o_finish_sector = fin_r;

	// ***********************************************************
	// Rate, precompensation and density select.
	// ***********************************************************

	logic [1:0] rate_r; // Effective rate code.
	logic [1:0] rate_nxt;
	logic prec_r; // Stored precomp disable flag.
	logic prec_nxt;
	logic dens_r; // Density select pin level.
	logic dens_nxt;

	// The most recent write wins; the rate register wins a same-cycle tie.
	assign rate_nxt = rate_wr ? i_wdata[ffrr_pkg::RATE_LSB +: 2] :
		(i_dsr_rate_wr ? i_dsr_rate : rate_r);
	// Only layout three stores the flag; soft reset leaves it alone.
	assign prec_nxt = (rate_wr && is_l3) ? i_wdata[ffrr_pkg::PRECOMP_BIT] : prec_r;
	// Density follows rate writes only, so resets of the core leave it.
	assign dens_nxt = (rate_wr || i_dsr_rate_wr) ? ffrr_pkg::dens_of(rate_nxt) : dens_r;

	// Soft reset is deliberately absent here: these values must survive it.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rate_r <= ffrr_pkg::RATE_RST;
			prec_r <= 1'b0;
			dens_r <= ffrr_pkg::DENS_RST;
		end else begin
			rate_r <= rate_nxt;
			prec_r <= prec_nxt;
			dens_r <= dens_nxt;
		end
	end
	assign o_rate_select_code = rate_r;
	assign o_precomp_disable = prec_r;
	assign o_density_select_out = dens_r;

	// ***********************************************************
	// Read path.
	// ***********************************************************

	wire [7:0] dir_data; // Status byte for the chosen layout.
	wire [7:0] dir_oe; // Its drive enables.

	ffrr_dir_mux u_dir (
		.i_mode(i_compat_mode),
		.i_media_changed_n(i_media_changed_n),
		.i_force_chg_en(i_force_chg_en),
		.i_force_chg_val(i_force_chg_val),
		.i_rate_select_code(rate_r),
		.i_precomp_disable(prec_r),
		.i_transfer_gate_enable(i_transfer_gate_enable),
		.o_data(dir_data),
		.o_oe(dir_oe)
	);

	// A data port read when not allowed returns zero and removes nothing.
	wire [7:0] rd_val = dir_rd ? dir_data : (host_pop ? head : 8'h00);
	wire [7:0] rd_oe = dir_rd ? dir_oe : 8'hff;

	logic [7:0] rdata_r; // Read data, valid one cycle after the strobe.
	logic [7:0] rdoe_r; // Drive enables for that cycle.

	// Data stand only in the cycle after the strobe, then the bus is released.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_r <= 8'h00;
			rdoe_r <= 8'h00;
		end else begin
			rdata_r <= i_rd ? rd_val : 8'h00;
			rdoe_r <= i_rd ? rd_oe : 8'h00;
		end
	end
	assign o_rdata = rdata_r;
	assign o_rdata_oe = rdoe_r;

	// ***********************************************************
	// Checks.
	// ***********************************************************

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	// An underrun during a disk write, then termination with sector finish.
	sequence s_write_underrun;
		underrun && i_disk_write && !i_soft_reset;
	endsequence
	sequence s_finish_report;
		o_xfer_abort && o_finish_sector;
	endsequence

	property p_soft_fifo_off;
		i_soft_reset |=> !fifo_en_r ##1 (!fifo_active || $past(i_cfg_load));
	endproperty
	a_soft_fifo_off: assert property (p_soft_fifo_off) else $error("fifo on after reset");

	property p_cfg_load;
		i_cfg_load && !i_soft_reset |=> fifo_en_r == $past(i_cfg_fifo_en) && thr_r == $past(i_cfg_threshold);
	endproperty
	a_cfg_load: assert property (p_cfg_load) else $error("configure not taken");

	property p_cmd_single;
		i_cmd_start |=> !fifo_active && !o_service_req;
	endproperty
	a_cmd_single: assert property (p_cmd_single) else $error("fifo live at command start");

	property p_exec_flush;
		i_exec_start |=> count == 5'h00;
	endproperty
	a_exec_flush: assert property (p_exec_flush) else $error("fifo not flushed");

	property p_err_stop;
		xfer_err && !i_soft_reset && !i_cmd_start |=> o_xfer_abort && !o_host_transfer_ready && halted;
	endproperty
	a_err_stop: assert property (p_err_stop) else $error("transfer not stopped");

	property p_finish_sector;
		s_write_underrun |=> s_finish_report;
	endproperty
	a_finish_sector: assert property (p_finish_sector) else $error("sector finish missing");

	property p_rate_write;
		rate_wr |=> o_rate_select_code == $past(i_wdata[1:0]) && o_density_select_out == ffrr_pkg::dens_of(o_rate_select_code);
	endproperty
	a_rate_write: assert property (p_rate_write) else $error("rate write lost");

	property p_rate_keep;
		!rate_wr && !i_dsr_rate_wr |=> $stable(o_rate_select_code) && $stable(o_density_select_out) && $stable(o_precomp_disable);
	endproperty
	a_rate_keep: assert property (p_rate_keep) else $error("rate changed without write");

	property p_dsr_rate;
		i_dsr_rate_wr && !rate_wr |=> o_rate_select_code == $past(i_dsr_rate);
	endproperty
	a_dsr_rate: assert property (p_dsr_rate) else $error("latest rate not used");

	property p_ready_gate;
		!fifo_active && !i_core_dir && !empty |-> !o_host_transfer_ready;
	endproperty
	a_ready_gate: assert property (p_ready_gate) else $error("ready while register full");

	property p_port_read;
		host_pop |=> o_rdata == $past(head) && o_rdata_oe == 8'hff ##1 o_rdata_oe == 8'h00 || $past(i_rd);
	endproperty
	a_port_read: assert property (p_port_read) else $error("data port read wrong");

	property p_layout1_oe;
		dir_rd && i_compat_mode == ffrr_pkg::MODE_LAYOUT1 |=> o_rdata_oe == 8'h80;
	endproperty
	a_layout1_oe: assert property (p_layout1_oe) else $error("low bits driven");
endmodule

// ---- verif/ffrr_host_model.sv ----
`timescale 1ns/1ps
// ***********************************************************
// Host processor model, master of the register port.
// ***********************************************************
module ffrr_host_model (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	input wire logic [7:0] i_rdata_oe,
	input wire logic i_host_transfer_ready,
	input wire logic i_transfer_direction,
	output logic [9:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	// Bus starts idle with both strobes low.
	initial begin
		o_addr = 10'h000;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	// One write cycle; address and data are scrambled once released.
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
		#1;
	endtask

	// One read cycle; data are taken in the single cycle they stand.
	task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic [7:0] oe);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1;
		d = rd_data_hold(i_rdata);
		oe = i_rdata_oe;
	endtask

	// Keeps the sampled byte as a separate value for the caller.
	function automatic logic [7:0] rd_data_hold(input logic [7:0] v);
		rd_data_hold = v;
	endfunction

	// Waits, bounded, until the flags allow a byte in the wanted direction.
	// Bytes are moved at once, well inside any threshold service window.
	task automatic pace(input logic want);
		int n;
		n = 0;
		while (!(i_host_transfer_ready === 1'b1 && i_transfer_direction === want) && n < 64) begin
			@(posedge i_clk);
			#1;
			n++;
		end
	endtask

	// Paced data port write.
	task automatic dp_wr(input logic [7:0] d);
		pace(1'b0);
		wr(ffrr_pkg::ADDR_DATA_PORT, d);
	endtask

	// Paced data port read.
	task automatic dp_rd(output logic [7:0] d);
		logic [7:0] oe;
		pace(1'b1);
		rd(ffrr_pkg::ADDR_DATA_PORT, d, oe);
	endtask

	// Rate write; reserved bits always go out as zero.
	task automatic rate_wr(input logic [1:0] code, input logic npc);
		wr(ffrr_pkg::ADDR_DIR_RATE, {5'h00, npc, code});
	endtask
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	// ***********************************************************
	// Stimulus, observed outputs and counters.
	// ***********************************************************
	logic i_clk, i_arst_n, i_wr, i_rd, i_soft_reset, i_cfg_load, i_cfg_fifo_en;
	logic i_cmd_start, i_exec_start, i_core_dir, i_disk_write, i_core_tx_valid;
	logic i_core_rx_ready, i_dsr_rate_wr, i_media_changed_n, i_force_chg_en;
	logic i_force_chg_val, i_transfer_gate_enable;
	logic [9:0] i_addr;
	logic [7:0] i_wdata, i_core_tx_data, o_rdata, o_rdata_oe, o_core_rx_data;
	logic [3:0] i_cfg_threshold;
	logic [1:0] i_compat_mode, i_dsr_rate, o_rate_select_code;
	logic o_core_tx_ready, o_core_rx_valid, o_host_transfer_ready, o_transfer_direction;
	logic o_service_req, o_xfer_abort, o_finish_sector, o_precomp_disable, o_density_select_out;
	int n_mismatch;
	int n_tests;

	ffrr_top u_ffrr_top (
		.i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_rdata_oe,
		.i_soft_reset, .i_compat_mode, .i_cfg_load, .i_cfg_fifo_en, .i_cfg_threshold,
		.i_cmd_start, .i_exec_start, .i_core_dir, .i_disk_write, .i_core_tx_valid,
		.i_core_tx_data, .o_core_tx_ready, .o_core_rx_valid, .o_core_rx_data, .i_core_rx_ready,
		.i_dsr_rate_wr, .i_dsr_rate, .i_media_changed_n, .i_force_chg_en, .i_force_chg_val,
		.i_transfer_gate_enable, .o_host_transfer_ready, .o_transfer_direction, .o_service_req,
		.o_xfer_abort, .o_finish_sector, .o_rate_select_code, .o_precomp_disable,
		.o_density_select_out
	);

	ffrr_host_model u_ffrr_host_model (
		.i_clk, .i_rdata(o_rdata), .i_rdata_oe(o_rdata_oe),
		.i_host_transfer_ready(o_host_transfer_ready),
		.i_transfer_direction(o_transfer_direction), .o_addr(i_addr), .o_wdata(i_wdata),
		.o_wr(i_wr), .o_rd(i_rd)
	);

	// 250 MHz clock.
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	// ***********************************************************
	// Shared helpers.
	// ***********************************************************
	// Compares one value and counts it; X never matches.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One-cycle pulse of {configure, soft reset, command start, execution start}.
	task automatic ctl(input logic [3:0] p);
		@(posedge i_clk);
		{i_cfg_load, i_soft_reset, i_cmd_start, i_exec_start} <= p;
		@(posedge i_clk);
		{i_cfg_load, i_soft_reset, i_cmd_start, i_exec_start} <= 4'h0;
		#1;
	endtask

	// Hardware reset held over four edges.
	task automatic hard_rst();
		@(posedge i_clk);
		i_arst_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		i_arst_n <= 1'b1;
		#1;
	endtask

	// Rate write through the other rate register.
	task automatic dsr(input logic [1:0] code);
		@(posedge i_clk);
		i_dsr_rate_wr <= 1'b1;
		i_dsr_rate <= code;
		@(posedge i_clk);
		i_dsr_rate_wr <= 1'b0;
		#1;
	endtask

	// ***********************************************************
	// Scenarios.
	// ***********************************************************
	// Status layout two straight after reset, plus an unmapped place.
	task automatic t_reset_vals();
		logic [7:0] d, oe;
		u_ffrr_host_model.rd(ffrr_pkg::ADDR_DIR_RATE, d, oe);
		chk(d, 8'h7d);
		chk(oe, 8'hff);
		chk(8'(o_rate_select_code), 8'h02);
		chk(8'(o_density_select_out), 8'h01);
		u_ffrr_host_model.wr(10'h3f6, 8'h01);
		u_ffrr_host_model.rd(10'h3f6, d, oe);
		chk(d, 8'h00);
		chk(8'(o_rate_select_code), 8'h02);
	endtask

	// Layout one: only bit 7, from the cable or from the forced value.
	task automatic t_layout1();
		logic [7:0] d, oe;
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk);
			i_compat_mode <= ffrr_pkg::MODE_LAYOUT1;
			i_media_changed_n <= k[0];
			i_force_chg_en <= k[1];
			i_force_chg_val <= k[0];
			u_ffrr_host_model.rd(ffrr_pkg::ADDR_DIR_RATE, d, oe);
			chk(oe, 8'h80);
			chk(d & 8'h80, {k[1] ? k[0] : ~k[0], 7'h00});
		end
		@(posedge i_clk);
		i_force_chg_en <= 1'b0;
		i_media_changed_n <= 1'b1;
		i_compat_mode <= ffrr_pkg::MODE_LAYOUT2;
	endtask

	// Every rate code in layout two, then the latest writer wins.
	task automatic t_rates();
		logic [7:0] d, oe;
		for (int c = 0; c < 4; c++) begin
			u_ffrr_host_model.rate_wr(c[1:0], 1'b0);
			u_ffrr_host_model.rd(ffrr_pkg::ADDR_DIR_RATE, d, oe);
			chk(d, {4'h7, 1'b1, c[1:0], c[0] ^ c[1]});
		end
		dsr(2'h1);
		u_ffrr_host_model.rate_wr(2'h0, 1'b0);
		chk(8'(o_rate_select_code), 8'h00);
		dsr(2'h1);
		chk(8'(o_rate_select_code), 8'h01);
	endtask

	// Layout three fields through soft and hard reset.
	task automatic t_layout3();
		logic [7:0] d, oe;
		@(posedge i_clk);
		i_compat_mode <= ffrr_pkg::MODE_LAYOUT3;
		i_transfer_gate_enable <= 1'b1;
		u_ffrr_host_model.rate_wr(2'h1, 1'b1);
		ctl(4'h4);
		u_ffrr_host_model.rd(ffrr_pkg::ADDR_DIR_RATE, d, oe);
		chk(d, 8'h0d);
		chk(8'(o_precomp_disable), 8'h01);
		chk(8'(o_density_select_out), 8'h00);
		@(posedge i_clk);
		i_transfer_gate_enable <= 1'b0;
		u_ffrr_host_model.rd(ffrr_pkg::ADDR_DIR_RATE, d, oe);
		chk(d, 8'h05);
		hard_rst();
		u_ffrr_host_model.rd(ffrr_pkg::ADDR_DIR_RATE, d, oe);
		chk(d, 8'h02);
		chk(8'(o_density_select_out), 8'h01);
	endtask

	// Single-byte register both ways, with a refused read.
	task automatic t_single();
		logic [7:0] d, oe;
		u_ffrr_host_model.dp_wr(8'ha5);
		chk(8'(o_host_transfer_ready), 8'h00);
		chk(o_core_rx_data, 8'ha5);
		u_ffrr_host_model.rd(ffrr_pkg::ADDR_DATA_PORT, d, oe);
		chk(d, 8'h00);
		@(posedge i_clk);
		i_core_rx_ready <= 1'b1;
		@(posedge i_clk);
		i_core_rx_ready <= 1'b0;
		i_core_dir <= 1'b1;
		i_core_tx_valid <= 1'b1;
		i_core_tx_data <= 8'h3c;
		@(posedge i_clk);
		i_core_tx_valid <= 1'b0;
		#1;
		chk(8'(o_transfer_direction), 8'h01);
		u_ffrr_host_model.dp_rd(d);
		chk(d, 8'h3c);
		chk(8'(o_host_transfer_ready), 8'h00);
	endtask

	// Full FIFO, flush, underrun, overrun and return to single mode.
	task automatic t_fifo();
		@(posedge i_clk);
		i_core_dir <= 1'b0;
		i_cfg_fifo_en <= 1'b1;
		i_cfg_threshold <= 4'h4;
		ctl(4'h8);
		ctl(4'h2);
		u_ffrr_host_model.dp_wr(8'h11);
		chk(8'(o_host_transfer_ready), 8'h00);
		ctl(4'h1);
		chk(8'(o_core_rx_valid), 8'h00);
		for (int i = 0; i < 16; i++) begin
			u_ffrr_host_model.dp_wr(8'h40 + i[7:0]);
			chk(o_host_transfer_ready, {7'h00, i < 15});
			chk(o_service_req, {7'h00, (15 - i) > 4});
		end
		@(posedge i_clk);
		i_core_rx_ready <= 1'b1;
		for (int j = 0; j < 16; j++) begin
			#1;
			chk(o_core_rx_data, 8'h40 + j[7:0]);
			@(posedge i_clk);
		end
		i_core_rx_ready <= 1'b0;
		i_disk_write <= 1'b1;
		@(posedge i_clk);
		i_core_rx_ready <= 1'b1;
		@(posedge i_clk);
		i_core_rx_ready <= 1'b0;
		#1;
		chk(8'({o_xfer_abort, o_finish_sector, o_host_transfer_ready}), 8'h06);
		@(posedge i_clk);
		i_disk_write <= 1'b0;
		#1;
		chk(8'(o_xfer_abort), 8'h00);
		ctl(4'h2);
		chk(8'(o_finish_sector), 8'h00);
		ctl(4'h1);
		@(posedge i_clk);
		i_core_dir <= 1'b1;
		i_core_tx_valid <= 1'b1;
		repeat (16) @(posedge i_clk);
		#1;
		chk(8'(o_core_tx_ready), 8'h00);
		@(posedge i_clk);
		i_core_tx_valid <= 1'b0;
		i_core_dir <= 1'b0;
		#1;
		chk(8'(o_xfer_abort), 8'h01);
		ctl(4'h4);
		ctl(4'h1);
		u_ffrr_host_model.dp_wr(8'h77);
		chk(8'(o_host_transfer_ready), 8'h00);
	endtask

	// ***********************************************************
	// Main sequence and verdict.
	// ***********************************************************
	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Every input gets a value at time zero, then the scenarios run.
	initial begin
		n_mismatch = 0;
		n_tests = 0;
		i_arst_n = 1'b0;
		{i_soft_reset, i_cfg_load, i_cfg_fifo_en, i_cmd_start, i_exec_start} = 5'h00;
		{i_core_dir, i_disk_write, i_core_tx_valid, i_core_rx_ready, i_dsr_rate_wr} = 5'h00;
		{i_force_chg_en, i_force_chg_val, i_transfer_gate_enable} = 3'h0;
		i_media_changed_n = 1'b1;
		i_compat_mode = ffrr_pkg::MODE_LAYOUT2;
		i_cfg_threshold = 4'h0;
		i_core_tx_data = 8'h00;
		i_dsr_rate = 2'h0;
		hard_rst();
		t_reset_vals();
		t_layout1();
		t_rates();
		t_layout3();
		t_single();
		t_fifo();
		tally_and_finish();
	end

	// The scenarios need well under a thousand cycles; ten thousand means a hang.
	initial begin
		#40000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule
